// >>> common/rsws_defines.svh
// Register offsets, field positions, reset values and timing figures of the reading store.
`ifndef RSWS_DEFINES_SVH
`define RSWS_DEFINES_SVH

`define RSWS_DEPTH        110000
`define RSWS_CAP_MIN      2
`define RSWS_CAP_DEFAULT  100
`define RSWS_BUSY_MIN     1000
`define RSWS_CLK_NS       5
`define RSWS_MS_NS        1000000
`define RSWS_HUND_NS      10000000

`define RSWS_OFF_CTRL     8'h00
`define RSWS_OFF_STATUS   8'h04
`define RSWS_OFF_CONFIG   8'h08
`define RSWS_OFF_CAP      8'h0c
`define RSWS_OFF_COUNT    8'h10
`define RSWS_OFF_NEXT     8'h14
`define RSWS_OFF_IDX      8'h18
`define RSWS_OFF_RDVAL    8'h1c
`define RSWS_OFF_RDSTAMP  8'h20
`define RSWS_OFF_RDDELTA  8'h24
`define RSWS_OFF_RDDATE   8'h28
`define RSWS_OFF_TIME     8'h2c
`define RSWS_OFF_DATE     8'h30
`define RSWS_OFF_MIN      8'h34
`define RSWS_OFF_MINLOC   8'h38
`define RSWS_OFF_MINSTAMP 8'h3c
`define RSWS_OFF_MAX      8'h40
`define RSWS_OFF_MAXLOC   8'h44
`define RSWS_OFF_MAXSTAMP 8'h48
`define RSWS_OFF_PKPK     8'h4c
`define RSWS_OFF_MEAN     8'h50
`define RSWS_OFF_SDEV     8'h54

`define RSWS_CTRL_START   0
`define RSWS_CTRL_ABORT   1
`define RSWS_CTRL_CLEAR   2
`define RSWS_CTRL_CALC    3
`define RSWS_CTRL_FACTORY 4
`define RSWS_CTRL_ACK     5

`define RSWS_CFG_AUTOCLR  0
`define RSWS_CFG_TSMODE   1
`define RSWS_CFG_CONT     2

`define RSWS_ST_ACTIVE    0
`define RSWS_ST_CALCRUN   1
`define RSWS_ST_BUSY      2
`define RSWS_ST_CLEARED   3
`define RSWS_ST_FULL      4
`define RSWS_ST_RTC       5
`define RSWS_ST_AUTOCLR   6

`endif

// >>> common/rsws_pkg.sv
// Types shared by the reading store and its arithmetic unit.
package rsws_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SCAN,
    ST_MEAN,
    ST_SQN,
    ST_VAR,
    ST_SQRT
  } rsws_state_t;

  typedef enum logic {
    OP_DIV,
    OP_SQRT
  } rsws_op_t;
endpackage

// >>> hw/rsws_divsqrt.sv
// Sequential unsigned divider and integer square root, one result bit per clock.
`timescale 1ns/100ps
module rsws_divsqrt (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire rsws_pkg::rsws_op_t op_i,
  input  wire logic             start_i,
  input  wire logic [97:0]      a_i,
  input  wire logic [97:0]      b_i,
  output logic      [97:0]      res_o,
  output logic                  done_o
);
  import rsws_pkg::*;

  logic [98:0] rem_ff;
  logic [97:0] src_ff;
  logic [97:0] quo_ff;
  logic [97:0] div_ff;
  logic [6:0]  cnt_ff;
  logic        run_ff;
  logic        done_ff;
  rsws_op_t    op_ff;
  logic [98:0] nxt_rem;
  logic [97:0] nxt_quo;
  logic [98:0] shifted;
  logic [98:0] trial;
  logic        fits;
  wire  [6:0]  last_cnt = (op_ff == OP_DIV) ? 7'h61 : 7'h30;

  // Division brings in one dividend bit per step, the root two radicand bits.
  always_comb begin
    if (op_ff == OP_DIV) begin
      shifted = {rem_ff[97:0], src_ff[97]};
      trial   = {1'b0, div_ff};
    end else begin
      shifted = {rem_ff[96:0], src_ff[97:96]};
      trial   = {quo_ff[96:0], 2'b01};
    end
    fits    = (shifted >= trial);
    nxt_rem = fits ? (shifted - trial) : shifted;
    nxt_quo = {quo_ff[96:0], fits};
  end

  // Iteration control; a new start while running is ignored by this unit.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff  <= 7'h00;
      op_ff   <= OP_DIV;
      rem_ff  <= '0;
      src_ff  <= '0;
      quo_ff  <= '0;
      div_ff  <= '0;
    end else if (start_i && !run_ff) begin
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
      cnt_ff  <= 7'h00;
      op_ff   <= op_i;
      rem_ff  <= '0;
      src_ff  <= a_i;
      quo_ff  <= '0;
      div_ff  <= b_i;
    end else begin
      done_ff <= run_ff && (cnt_ff == last_cnt);
      if (run_ff) begin
        rem_ff <= nxt_rem;
        quo_ff <= nxt_quo;
        src_ff <= (op_ff == OP_DIV) ? {src_ff[96:0], 1'b0} : {src_ff[95:0], 2'b00};
        cnt_ff <= cnt_ff + 7'h01;
        run_ff <= (cnt_ff != last_cnt);
      end
    end
  end

  assign res_o  = quo_ff;
  assign done_o = done_ff;
endmodule

// >>> hw/rsws_store.sv
// Reading store with timestamps, append and wrap modes, and buffer statistics.
// Function
// R1: Auto-clear on: store is emptied before every new storage run starts.
// R2: Writing capacity zero empties the store at once, capacity unchanged.
// R3: Auto-clear off: keep readings, capacity forced to 110000, later runs append.
// R4: Append mode halts at 110000 readings; full store is emptied on next start.
// R5: Auto-clear off: capacities other than 110000 or zero are refused.
// R6: Power-up turns auto-clear on if the store is empty, else keeps it.
// R7: Ordinary reset keeps auto-clear; only factory defaults force it on. Here a reset also turns it on when the store is empty.
// R8: Any change of the auto-clear setting empties the store.
// R9: Relative stamps: millisecond time from first reading, plus delta to previous.
// R10: Appended readings stay referenced to reading zero across stops and restarts.
// R11: After a power cycle the relative time base restarts from zero.
// R12: Calendar mode tags time of day with hundredths, and the date.
// R13: Timestamp mode change empties store and flags it only while storing.
// R14: Capacity takes 2 to 110000; active indicator spans armed to finished.
// R15: Controller may abort a run; further readings are then refused.
// R16: Stored readings survive power cycling.
// R17: Continuous mode wraps the write pointer to location zero, overwriting oldest.
// R18: Minimum and maximum are reported with location and timestamp.
// R19: Peak-to-peak is maximum minus minimum.
// R20: Mean is sum of readings divided by their count.
// R21: Standard deviation is the sample form using n minus one.
// R22: Over 1000 readings the deviation run shows busy and ignores key input.
// R23: Each entry keeps its reading, location and timestamp together.
// R24: Readings fill from location zero; statistics cover exactly held readings.
`timescale 1ns/100ps
`include "rsws_defines.svh"
module rsws_store #(
  parameter int unsigned MS_CYCLES = `RSWS_MS_NS / `RSWS_CLK_NS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        nv_rst_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        reading_valid_i,
  input  wire logic [31:0] reading_i,
  output logic             storage_active_o,
  output logic             statistic_busy_indication_o,
  output logic             buffer_cleared_o
);
  import rsws_pkg::*;

  localparam logic [16:0] DEPTH    = 17'(`RSWS_DEPTH);
  localparam logic [16:0] CAP_MIN  = 17'(`RSWS_CAP_MIN);
  localparam logic [16:0] CAP_DEF  = 17'(`RSWS_CAP_DEFAULT);
  localparam logic [16:0] BUSY_MIN = 17'(`RSWS_BUSY_MIN);
  localparam logic [3:0]  HUND_MS  = 4'(`RSWS_HUND_NS / `RSWS_MS_NS);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [63:0] mag64(input logic [63:0] v);
    mag64 = v[63] ? (64'h0 - v) : v;
  endfunction

  // Entry arrays carry no reset: their contents are meant to outlive power cycles.
  logic [31:0] mem_val [0:`RSWS_DEPTH-1];
  logic [31:0] mem_ts  [0:`RSWS_DEPTH-1];
  logic [15:0] mem_dt  [0:`RSWS_DEPTH-1];

  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic        auto_clear_policy_ff;
  logic        timestamp_mode_select_ff;
  logic        cont_ff;
  logic        contents_rtc_ff;
  logic [16:0] cap_ff;
  logic [16:0] count_ff;
  logic [16:0] wr_ptr_ff;
  logic [16:0] idx_ff;
  logic        active_ff;
  logic        cleared_ff;
  logic [31:0] ref_ms_ff;
  logic [31:0] ms_now_ff;
  logic [17:0] ms_div_ff;
  logic [3:0]  hund_div_ff;
  logic [23:0] tod_ff;
  logic [23:0] nxt_tod;
  logic [15:0] date_ff;

  // Host requests: every access is answered on the second cycle.
  wire wr_go   = avs_write_i && !wait_ff && (avs_byteenable_i == 4'hf)
                 && !statistic_busy_indication_o;
  wire rd_take = avs_read_i && wait_ff;
  wire [31:0] wd = avs_writedata_i;
  wire wr_ctrl = wr_go && hit(avs_address_i, `RSWS_OFF_CTRL);
  wire wr_cfg  = wr_go && hit(avs_address_i, `RSWS_OFF_CONFIG);
  wire wr_cap  = wr_go && hit(avs_address_i, `RSWS_OFF_CAP);
  wire wr_idx  = wr_go && hit(avs_address_i, `RSWS_OFF_IDX);
  wire wr_time = wr_go && hit(avs_address_i, `RSWS_OFF_TIME);
  wire wr_date = wr_go && hit(avs_address_i, `RSWS_OFF_DATE);
  wire cmd_start   = wr_ctrl && wd[`RSWS_CTRL_START];
  wire cmd_abort   = wr_ctrl && wd[`RSWS_CTRL_ABORT];
  wire cmd_clear   = wr_ctrl && wd[`RSWS_CTRL_CLEAR];
  wire cmd_calc    = wr_ctrl && wd[`RSWS_CTRL_CALC];
  wire cmd_factory = wr_ctrl && wd[`RSWS_CTRL_FACTORY];
  wire cmd_ack     = wr_ctrl && wd[`RSWS_CTRL_ACK];

  // Store emptying causes.
  wire new_ac    = wd[`RSWS_CFG_AUTOCLR];
  wire new_ts    = wd[`RSWS_CFG_TSMODE];
  wire cap_zero  = wr_cap && (wd == 32'h0);                                    // R2
  wire ac_change = wr_cfg && (new_ac != auto_clear_policy_ff);                 // R8
  wire ts_clear  = wr_cfg && (new_ts != timestamp_mode_select_ff) && active_ff; // R13
  wire full      = (count_ff == DEPTH);
  wire start_clr = cmd_start && (auto_clear_policy_ff || full);                // R1 R4
  wire clear_any = cap_zero || ac_change || ts_clear || cmd_clear || cmd_factory || start_clr;
  wire cap_legal = (wd >= 32'(CAP_MIN)) && (wd <= 32'(DEPTH));                 // R14
  wire acc       = active_ff && reading_valid_i && !clear_any;                 // R15
  wire last_slot = (wr_ptr_ff == cap_ff - 17'h1);
  wire finishing = acc && !cont_ff && (count_ff + 17'h1 >= cap_ff);            // R4 R14
  wire ms_tick   = (ms_div_ff == 18'(MS_CYCLES - 1));

  // Bus handshake and read data capture.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= !((avs_read_i || avs_write_i) && wait_ff);
      if (rd_take) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Policy, mode and capacity live in the nonvolatile domain.
  always_ff @(posedge core_clk_i) begin
    if (!nv_rst_n_i) begin
      auto_clear_policy_ff     <= 1'b1;
      timestamp_mode_select_ff <= 1'b0;
      cont_ff                  <= 1'b0;
      cap_ff                   <= CAP_DEF;
    end else if (!rst_n_i) begin
      auto_clear_policy_ff <= (count_ff == 17'h0) ? 1'b1 : auto_clear_policy_ff; // R6 R7
    end else if (cmd_factory) begin
      auto_clear_policy_ff <= 1'b1;                                           // R7
      cap_ff               <= CAP_DEF;
    end else if (wr_cfg) begin
      auto_clear_policy_ff     <= new_ac;
      timestamp_mode_select_ff <= new_ts;
      cont_ff                  <= wd[`RSWS_CFG_CONT];
      cap_ff                   <= new_ac ? cap_ff : DEPTH;                    // R3
    end else if (wr_cap && !cap_zero) begin
      cap_ff <= !auto_clear_policy_ff ? DEPTH : (cap_legal ? wd[16:0] : cap_ff); // R5 R14
    end
  end

  // Fill level and write pointer, kept over power cycles with the entries.
  always_ff @(posedge core_clk_i) begin
    if (!nv_rst_n_i || clear_any) begin
      count_ff        <= 17'h0;
      wr_ptr_ff       <= 17'h0;
      contents_rtc_ff <= 1'b0;
    end else if (acc) begin
      count_ff        <= (count_ff == cap_ff) ? count_ff : count_ff + 17'h1;  // R24
      wr_ptr_ff       <= last_slot ? 17'h0 : wr_ptr_ff + 17'h1;               // R17
      contents_rtc_ff <= (count_ff == 17'h0) ? timestamp_mode_select_ff : contents_rtc_ff;
    end
  end

  // Entry write: value, stamp and date share one location.
  wire [31:0] rel_stamp = ms_now_ff - ((count_ff == 17'h0) ? ms_now_ff : ref_ms_ff); // R9 R10
  wire [31:0] rtc_stamp = {8'h00, tod_ff};                                    // R12
  always_ff @(posedge core_clk_i) begin
    if (acc) begin
      mem_val[wr_ptr_ff] <= reading_i;                                        // R16 R23
      mem_ts[wr_ptr_ff]  <= timestamp_mode_select_ff ? rtc_stamp : rel_stamp;
      mem_dt[wr_ptr_ff]  <= date_ff;
    end
  end

  // Run control; a power cycle stops any run but never touches the entries.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active_ff  <= 1'b0;
      cleared_ff <= 1'b0;
      idx_ff     <= 17'h0;
    end else begin
      if (cmd_abort || finishing) begin
        active_ff <= 1'b0;                                                    // R15 R14
      end else if (cmd_start) begin
        active_ff <= 1'b1;                                                    // R14
      end
      cleared_ff <= ts_clear || (cleared_ff && !cmd_ack);                     // R13
      if (wr_idx) begin
        idx_ff <= wd[16:0];
      end
    end
  end

  // Relative time base starts at zero on every power-up.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ms_div_ff <= 18'h0;
      ms_now_ff <= 32'h0;                                                     // R11
      ref_ms_ff <= 32'h0;                                                     // R11
    end else begin
      ms_div_ff <= ms_tick ? 18'h0 : ms_div_ff + 18'h1;
      ms_now_ff <= ms_tick ? ms_now_ff + 32'h1 : ms_now_ff;
      if (acc && (count_ff == 17'h0)) begin
        ref_ms_ff <= ms_now_ff;                                               // R9
      end
    end
  end

  // Time of day rolls at midnight; the date only changes when software sets it.
  always_comb begin
    nxt_tod = tod_ff;
    if (tod_ff[6:0] != 7'h63) begin
      nxt_tod[6:0] = tod_ff[6:0] + 7'h1;
    end else begin
      nxt_tod[6:0] = 7'h0;
      if (tod_ff[12:7] != 6'h3b) begin
        nxt_tod[12:7] = tod_ff[12:7] + 6'h1;
      end else begin
        nxt_tod[12:7] = 6'h0;
        if (tod_ff[18:13] != 6'h3b) begin
          nxt_tod[18:13] = tod_ff[18:13] + 6'h1;
        end else begin
          nxt_tod[18:13] = 6'h0;
          nxt_tod[23:19] = (tod_ff[23:19] == 5'h17) ? 5'h0 : tod_ff[23:19] + 5'h1;
        end
      end
    end
  end

  // Calendar clock keeps its time through ordinary resets but does not advance while they last.
  always_ff @(posedge core_clk_i) begin
    if (!nv_rst_n_i) begin
      hund_div_ff <= 4'h0;
      tod_ff      <= 24'h0;
      date_ff     <= 16'h0;
    end else begin
      if (wr_time) begin
        tod_ff      <= wd[23:0];
        hund_div_ff <= 4'h0;
      end else if (ms_tick) begin
        hund_div_ff <= (hund_div_ff == HUND_MS - 4'h1) ? 4'h0 : hund_div_ff + 4'h1;
        tod_ff      <= (hund_div_ff == HUND_MS - 4'h1) ? nxt_tod : tod_ff;    // R12
      end
      if (wr_date) begin
        date_ff <= wd[15:0];
      end
    end
  end

  // Statistics engine.
  rsws_state_t  state_ff;
  logic [16:0]  n_ff;
  logic [16:0]  scan_ff;
  logic         launched_ff;
  logic [31:0]  min_ff;
  logic [31:0]  max_ff;
  logic [16:0]  min_loc_ff;
  logic [16:0]  max_loc_ff;
  logic [31:0]  min_ts_ff;
  logic [31:0]  max_ts_ff;
  logic [63:0]  sum_ff;
  logic [97:0]  sumsq_ff;
  logic [97:0]  sqn_ff;
  logic [31:0]  mean_ff;
  logic [31:0]  sdev_ff;
  logic         busy_ff;
  logic [97:0]  du_res;
  logic         du_done;

  wire [31:0] sv       = mem_val[scan_ff];
  wire [63:0] sv_ext   = {{32{sv[31]}}, sv};
  wire [63:0] sv_sq    = mag64(sv_ext) * mag64(sv_ext);
  wire        first    = (scan_ff == 17'h0);
  wire [63:0] sum_mag  = mag64(sum_ff);
  wire [97:0] sum_sq   = 98'(sum_mag) * 98'(sum_mag);
  wire [97:0] var_num  = (sumsq_ff > sqn_ff) ? (sumsq_ff - sqn_ff) : 98'h0;
  wire        op_state = (state_ff == ST_MEAN) || (state_ff == ST_SQN)
                         || (state_ff == ST_VAR) || (state_ff == ST_SQRT);
  wire        du_start = op_state && !launched_ff;
  wire rsws_op_t du_op = (state_ff == ST_SQRT) ? OP_SQRT : OP_DIV;
  wire [97:0] du_a     = (state_ff == ST_MEAN) ? 98'(sum_mag) :                // R20
                         (state_ff == ST_SQN)  ? sum_sq :
                         (state_ff == ST_VAR)  ? var_num : sqn_ff;            // R21
  wire [97:0] du_b     = (state_ff == ST_VAR) ? 98'(n_ff - 17'h1) : 98'(n_ff);

  rsws_divsqrt u_divsqrt (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .op_i       (du_op),
    .start_i    (du_start),
    .a_i        (du_a),
    .b_i        (du_b),
    .res_o      (du_res),
    .done_o     (du_done)
  );

  // Walk of the held readings, one per clock, then the arithmetic chain.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      n_ff        <= 17'h0;
      scan_ff     <= 17'h0;
      launched_ff <= 1'b0;
    end else begin
      launched_ff <= du_done ? 1'b0 : (launched_ff || du_start);
      case (state_ff)
        ST_IDLE: begin
          if (cmd_calc) begin
            n_ff     <= count_ff;                                             // R24
            scan_ff  <= 17'h0;
            state_ff <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          scan_ff  <= scan_ff + 17'h1;
          state_ff <= (scan_ff + 17'h1 >= n_ff) ? ((n_ff == 17'h0) ? ST_IDLE : ST_MEAN) : ST_SCAN;
        end
        ST_MEAN: state_ff <= du_done ? ST_SQN : ST_MEAN;
        ST_SQN: state_ff <= du_done ? ((n_ff < CAP_MIN) ? ST_IDLE : ST_VAR) : ST_SQN;
        ST_VAR: state_ff <= du_done ? ST_SQRT : ST_VAR;
        ST_SQRT: state_ff <= du_done ? ST_IDLE : ST_SQRT;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Accumulators and extremes; strict compares keep the earliest location on ties.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || (state_ff == ST_IDLE && cmd_calc)) begin
      sum_ff   <= 64'h0;
      sumsq_ff <= 98'h0;
      min_ff   <= 32'h0;
      max_ff   <= 32'h0;
    end else if (state_ff == ST_SCAN && n_ff != 17'h0) begin
      sum_ff   <= sum_ff + sv_ext;
      sumsq_ff <= sumsq_ff + 98'(sv_sq);
      if (first || $signed(sv) < $signed(min_ff)) begin
        min_ff     <= sv;                                                     // R18
        min_loc_ff <= scan_ff;
        min_ts_ff  <= mem_ts[scan_ff];
      end
      if (first || $signed(sv) > $signed(max_ff)) begin
        max_ff     <= sv;                                                     // R18
        max_loc_ff <= scan_ff;
        max_ts_ff  <= mem_ts[scan_ff];
      end
    end
  end

  // Results of the divide and root steps.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || (state_ff == ST_IDLE && cmd_calc)) begin
      mean_ff <= 32'h0;
      sqn_ff  <= 98'h0;
      sdev_ff <= 32'h0;
    end else if (du_done) begin
      if (state_ff == ST_MEAN) begin
        mean_ff <= sum_ff[63] ? (32'h0 - du_res[31:0]) : du_res[31:0];       // R20
      end
      if (state_ff == ST_SQN || state_ff == ST_VAR) begin
        sqn_ff <= du_res;
      end
      if (state_ff == ST_SQRT) begin
        sdev_ff <= du_res[31:0];                                              // R21
      end
    end
  end

  // Long runs lock out control writes so the result cannot be disturbed.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff == ST_IDLE) ? (cmd_calc && count_ff > BUSY_MIN)    // R22
                 : !(state_ff == ST_SQRT && du_done) && busy_ff;
    end
  end

  // Readback of one entry; delta is only meaningful for relative contents.
  wire        idx_ok  = (idx_ff < count_ff);
  wire [16:0] idx_pre = (idx_ff == 17'h0) ? 17'h0 : idx_ff - 17'h1;
  wire [31:0] e_val   = idx_ok ? mem_val[idx_ff] : 32'h0;
  wire [31:0] e_ts    = idx_ok ? mem_ts[idx_ff] : 32'h0;
  wire [31:0] e_delta_tag = (idx_ok && !contents_rtc_ff && idx_ff != 17'h0)
                            ? (mem_ts[idx_ff] - mem_ts[idx_pre]) : 32'h0;     // R9
  wire [15:0] e_date  = idx_ok ? mem_dt[idx_ff] : 16'h0;
  wire [31:0] status_w = {25'h0, auto_clear_policy_ff, contents_rtc_ff, full, cleared_ff,
                          busy_ff, (state_ff != ST_IDLE), active_ff};

  // Read data selection; unmapped words read zero.
  always_comb begin
    case (avs_address_i)
      `RSWS_OFF_STATUS:   rd_mux = status_w;
      `RSWS_OFF_CONFIG:   rd_mux = {29'h0, cont_ff, timestamp_mode_select_ff, auto_clear_policy_ff};
      `RSWS_OFF_CAP:      rd_mux = {15'h0, cap_ff};
      `RSWS_OFF_COUNT:    rd_mux = {15'h0, count_ff};
      `RSWS_OFF_NEXT:     rd_mux = {15'h0, wr_ptr_ff};
      `RSWS_OFF_IDX:      rd_mux = {15'h0, idx_ff};
      `RSWS_OFF_RDVAL:    rd_mux = e_val;
      `RSWS_OFF_RDSTAMP:  rd_mux = e_ts;
      `RSWS_OFF_RDDELTA:  rd_mux = e_delta_tag;
      `RSWS_OFF_RDDATE:   rd_mux = {16'h0, e_date};
      `RSWS_OFF_TIME:     rd_mux = {8'h0, tod_ff};
      `RSWS_OFF_DATE:     rd_mux = {16'h0, date_ff};
      `RSWS_OFF_MIN:      rd_mux = min_ff;
      `RSWS_OFF_MINLOC:   rd_mux = {15'h0, min_loc_ff};
      `RSWS_OFF_MINSTAMP: rd_mux = min_ts_ff;
      `RSWS_OFF_MAX:      rd_mux = max_ff;
      `RSWS_OFF_MAXLOC:   rd_mux = {15'h0, max_loc_ff};
      `RSWS_OFF_MAXSTAMP: rd_mux = max_ts_ff;
      `RSWS_OFF_PKPK:     rd_mux = max_ff - min_ff;                           // R19
      `RSWS_OFF_MEAN:     rd_mux = mean_ff;
      `RSWS_OFF_SDEV:     rd_mux = sdev_ff;
      default:            rd_mux = 32'h0;
    endcase
  end

  assign avs_readdata_o              = rdata_ff;
  assign avs_waitrequest_o           = wait_ff;
  assign storage_active_o            = active_ff;
  assign statistic_busy_indication_o = busy_ff;
  assign buffer_cleared_o            = cleared_ff;
endmodule

// >>> dv/rsws_props.sv
// Checker on the store's bus handshake and run flags.
`timescale 1ns/100ps
module rsws_props (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        storage_active_o,
  input wire logic        statistic_busy_indication_o,
  input wire logic        buffer_cleared_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // An accepted control write; while busy the store ignores writes.
  wire cw = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
    && avs_byteenable_i == 4'hf && !statistic_busy_indication_o;
  wire [31:0] d = avs_writedata_i;
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("late answer");
  wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("long answer");
  run_arm_a: assert property (cw && d[5:0] == 6'h01 |=> storage_active_o)
    else $error("start ignored");
  run_cause_a: assert property ($rose(storage_active_o) |-> $past(cw && d[0]))
    else $error("stray start");
  run_abort_a: assert property (cw && d[1:0] == 2'h2 |=> !storage_active_o)
    else $error("abort ignored");
  clear_cause_a: assert property ($rose(buffer_cleared_o) |-> $past(storage_active_o))
    else $error("flag while idle");
  clear_hold_a: assert property (buffer_cleared_o && !(cw && d[5]) |=> buffer_cleared_o)
    else $error("flag lost");
  clear_ack_a: assert property (cw && d[5] |=> !buffer_cleared_o)
    else $error("ack ignored");
  busy_cause_a: assert property ($rose(statistic_busy_indication_o) |-> $past(cw && d[3]))
    else $error("stray busy");
  cover property ($fell(storage_active_o));
  cover property ($rose(buffer_cleared_o));
  cover property (cw && d[1]);
endmodule
bind rsws_store rsws_props u_props (.*);

// >>> dv/rsws_src.sv
// Reading source model: one reading a cycle while enabled.
`timescale 1ns/100ps
module rsws_src (
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  output logic             valid_o,
  output logic      [31:0] value_o
);
  logic odd_ff = 1'b0;
  initial valid_o = 1'b0;
  initial value_o = 32'h0;
  // Readings alternate 10 and -4; idle data toggles so it never looks stale-valid.
  always @(posedge core_clk_i) begin
    odd_ff <= ~odd_ff;
    valid_o <= go_i;
    value_o <= !go_i ? ~value_o : odd_ff ? 32'hfffffffc : 32'h0000000a;
  end
endmodule

// >>> dv/reading_store_with_stats_test.sv
// Self-checking bench for the reading store.
`timescale 1ns/100ps
module reading_store_with_stats_test;
  logic        clk = 1'b0, rst_n = 1'b0, nv_n = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rv;
  logic        wq, vld, act, busy, clr;
  int          errors = 0, compares = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  rsws_store #(.MS_CYCLES(10)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .nv_rst_n_i(nv_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .reading_valid_i(vld), .reading_i(rv), .storage_active_o(act),
    .statistic_busy_indication_o(busy), .buffer_cleared_o(clr));
  rsws_src SRC (.core_clk_i(clk), .go_i(go), .valid_o(vld), .value_o(rv));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until the edge that shows waitrequest low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task automatic feed(input int n);
    go <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic run(input int n);
    bus(1'b1, 8'h00, 32'h1);
    feed(n);
  endtask
  task automatic t_stats();
    rchk("config", 8'h08, 32'h1);
    bus(1'b1, 8'h0c, 32'h2);
    run(4);
    rchk("count", 8'h10, 32'h2);
    chk("active", 32'h0, {31'h0, act});
    bus(1'b1, 8'h18, 32'h0);
    rchk("stamp", 8'h20, 32'h0);
    bus(1'b1, 8'h00, 32'h8);
    do bus(1'b0, 8'h04, 32'h0); while (rdat[1] !== 1'b0 && cyc < 9000);
    rchk("min", 8'h34, 32'hfffffffc);
    rchk("max", 8'h40, 32'ha);
    rchk("pkpk", 8'h4c, 32'he);
    rchk("mean", 8'h50, 32'h3);
    rchk("sdev", 8'h54, 32'h9);
    run(4);
    rchk("count", 8'h10, 32'h2);
  endtask
  task automatic t_keep();
    bus(1'b1, 8'h08, 32'h0);
    rchk("count", 8'h10, 32'h0);
    rchk("capacity", 8'h0c, 32'h1adb0);
    bus(1'b1, 8'h0c, 32'h5);
    rchk("capacity", 8'h0c, 32'h1adb0);
    run(3);
    bus(1'b1, 8'h00, 32'h2);
    feed(3);
    rchk("count", 8'h10, 32'h3);
    run(2);
    rchk("count", 8'h10, 32'h5);
    bus(1'b1, 8'h00, 32'h2);
  endtask
  task automatic t_power();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk("config", 8'h08, 32'h0);
    rchk("count", 8'h10, 32'h5);
    run(1);
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk("cleared", 32'h1, {31'h0, rdat[3]});
    rchk("count", 8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h20);
    feed(1001);
    bus(1'b1, 8'h00, 32'h8);
    bus(1'b1, 8'h00, 32'h4);
    bus(1'b0, 8'h04, 32'h0);
    chk("busy", 32'h1, {31'h0, rdat[2]});
    rchk("count", 8'h10, 32'h3e9);
    do bus(1'b0, 8'h04, 32'h0); while (rdat[2] !== 1'b0 && cyc < 9000);
    bus(1'b1, 8'h0c, 32'h0);
    rchk("count", 8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h10);
    rchk("config", 8'h08, 32'h3);
    bus(1'b1, 8'h0c, 32'h2);
    bus(1'b1, 8'h08, 32'h7);
    run(3);
    rchk("next", 8'h14, 32'h1);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hung handshake ends the run here as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    nv_n <= 1'b1;
    t_stats();
    t_keep();
    t_power();
    complete_run();
  end
endmodule
